/* write_guard_power_clock_ctl.sv */
// Write guards, power modes and system clock control with an APB slave
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RQ1: Writing 0xaa then 0x55 to the single guard arms one protected write.
// RQ2: One protected write consumes the single guard; next write needs new unlock.
// RQ3: Reads of single-guard protected registers never depend on guard state.
// RQ4: Single guard protects watchdog restart bit, memory and address config.
// RQ5: An armed single guard has no timeout.
// RQ6: Any access to the single guard register while armed relocks it.
// RQ7: Single guard register reads unlocked state in bit 0.
// RQ8: Writing 0xaa then 0x55 to the timed guard opens 256-cycle window.
// RQ9: Repeating the timed unlock while open restarts the full window.
// RQ10: Writing 0x00 to the timed guard closes the window at once.
// RQ11: Timed guard register reads window state in bit 0.
// RQ12: Guards run on the CPU clock and stay armed during IDLE or STOP; here they run on clk_in and the timed window keeps counting down.
// RQ13: Idle bit stops CPU clock; interrupt ends IDLE and clears the bit.
// RQ14: Stop bit alone gates all clocks until unclocked wake or reset.
// RQ15: Sleep and stop bits together enter SLEEP with regulator off.
// RQ16: Leaving SLEEP clears sleep and stop bits in hardware.
// RQ17: Upper divider bit reads zero; reduced-rate mode is unreachable.
// RQ18: Four-bit prescale field selects fast oscillator divide ratio.
// RQ19: Clock select resets to 0x0c; writes only land inside timed window.
// RQ20: Regulator settle field picks 8, 16, 64 or 256 slow cycles delay.
// RQ21: Clock source field picks divided fast, slow or external clock.
// RQ22: Watchdog restart write of 1 acts only while single guard armed.
// RQ23: Protected writes while locked or expired are ignored silently.
module write_guard_power_clock_ctl (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [9:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        wake_in,
  input  wire logic        idle_wake_in,
  input  wire logic        low_speed_clk_in,
  output logic             cpu_clk_stop_out,
  output logic             periph_clk_stop_out,
  output logic             regulator_off_out,
  output logic      [1:0]  clock_source_out,
  output logic      [8:0]  fast_osc_divisor_out,
  output logic             full_speed_out,
  output logic             auto_return_out,
  output logic      [7:0]  memory_config_out,
  output logic      [7:0]  address_config_out,
  output logic             watchdog_restart_out,
  output logic             guard_unlocked_out,
  output logic             window_open_out
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  ctl_pkg::apb_req_type   req;
  ctl_pkg::ctl_state_type st_r;
  ctl_pkg::ctl_state_type st_nxt;
  logic       acc;
  logic       wr;
  logic [7:0] wd;
  logic       hit_mode;
  logic       hit_clock_sel;
  logic       hit_manage;
  logic       hit_guard;
  logic       hit_window;
  logic       hit_wdog;
  logic       hit_mem;
  logic       hit_addr;
  logic       hit_any;
  logic       window_open;
  logic       wake;
  logic       slow_tick;
  logic       prot_wr;
  logic [7:0] rd_val;
  logic [8:0] settle_limit;

  function automatic logic reg_hit(input logic [9:0] a, input logic [7:0] idx);
    reg_hit = (a[9:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
                 paddr: paddr_in, pwdata: pwdata_in};

  assign acc        = req.psel && req.penable;
  assign wr         = acc && req.pwrite;
  assign wd         = req.pwdata[7:0];
  assign hit_mode      = reg_hit(req.paddr, ctl_pkg::IDX_POWER_MODE_CONTROL);
  assign hit_clock_sel = reg_hit(req.paddr, ctl_pkg::IDX_SYSTEM_CLOCK_SELECT);
  assign hit_manage    = reg_hit(req.paddr, ctl_pkg::IDX_POWER_MANAGE_DIV);
  assign hit_guard  = reg_hit(req.paddr, ctl_pkg::IDX_SINGLE_WRITE_GUARD);
  assign hit_window = reg_hit(req.paddr, ctl_pkg::IDX_TIMED_WINDOW_GUARD);
  assign hit_wdog   = reg_hit(req.paddr, ctl_pkg::IDX_WATCHDOG_CONTROL);
  assign hit_mem    = reg_hit(req.paddr, ctl_pkg::IDX_MEMORY_CONFIG);
  assign hit_addr   = reg_hit(req.paddr, ctl_pkg::IDX_ADDRESS_CONFIG);
  assign hit_any    = hit_mode | hit_clock_sel | hit_manage | hit_guard | hit_window
                    | hit_wdog | hit_mem | hit_addr;

  // Zero wait state; unmapped addresses answer with an error
  assign pready_out  = acc;
  assign pslverr_out = acc && !hit_any;

  assign window_open = (st_r.window_cnt != 9'h000);
  assign wake        = st_r.wake_sync[1];
  assign slow_tick   = st_r.low_speed_sync[1] && !st_r.low_speed_sync[2];
  assign prot_wr     = wr && (hit_mem || hit_addr || hit_wdog);

  // ---------------------------------------------------------------
  // Read data, latched in the setup cycle
  // ---------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    if (hit_mode) begin
      rd_val[ctl_pkg::MODE_BAUD_BIT] = st_r.baud_double_reserved;
    end
    if (hit_clock_sel) begin
      rd_val = {st_r.system_clock_select[7:4], 2'b00, st_r.system_clock_select[1:0]};
    end
    if (hit_manage) begin
      rd_val[ctl_pkg::DIV_LOW_BIT]      = st_r.divider_ctl_low; // RQ17
      rd_val[ctl_pkg::DIV_AUTO_RET_BIT] = st_r.auto_return_bit;
    end
    if (hit_guard) begin
      rd_val[0] = st_r.guard_unlocked_flag; // RQ7
    end
    if (hit_window) begin
      rd_val[0] = window_open; // RQ11
    end
    if (hit_mem) begin
      rd_val = st_r.memory_config_reg; // RQ3
    end
    if (hit_addr) begin
      rd_val = st_r.address_config_reg; // RQ3
    end
  end

  always_comb begin
    case (st_r.system_clock_select[3:2]) // RQ20
      2'b00:   settle_limit = ctl_pkg::SETTLE_CODE0;
      2'b01:   settle_limit = ctl_pkg::SETTLE_CODE1;
      2'b10:   settle_limit = ctl_pkg::SETTLE_CODE2;
      default: settle_limit = ctl_pkg::SETTLE_CODE3;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.wake_sync      = {st_r.wake_sync[0], wake_in};
    st_nxt.low_speed_sync = {st_r.low_speed_sync[1:0], low_speed_clk_in};
    st_nxt.watchdog_restart = 1'b0;
    if (req.psel && !req.penable) begin
      st_nxt.rdata = {24'h000000, rd_val};
    end

    // Single-use guard; armed state has no timeout
    if (acc && hit_guard) begin
      if (st_r.guard_unlocked_flag) begin
        st_nxt.guard_unlocked_flag = 1'b0; // RQ6
        st_nxt.guard_stage         = 1'b0;
      end else if (req.pwrite) begin
        if (st_r.guard_stage && wd == ctl_pkg::UNLOCK_SECOND) begin
          st_nxt.guard_unlocked_flag = 1'b1; // RQ1
        end
        st_nxt.guard_stage = (wd == ctl_pkg::UNLOCK_FIRST);
      end
    end
    if (prot_wr && st_r.guard_unlocked_flag) begin // RQ4 RQ5
      st_nxt.guard_unlocked_flag = 1'b0; // RQ2
      if (hit_mem) begin
        st_nxt.memory_config_reg = wd;
      end
      if (hit_addr) begin
        st_nxt.address_config_reg = wd;
      end
      if (hit_wdog) begin
        st_nxt.watchdog_restart = wd[ctl_pkg::RESTART_BIT]; // RQ22
      end
    end

    // Timed window guard
    if (window_open) begin
      st_nxt.window_cnt = st_r.window_cnt - 9'h001;
    end
    if (wr && hit_window) begin
      if (wd == ctl_pkg::WINDOW_CLOSE) begin
        st_nxt.window_cnt   = 9'h000; // RQ10
        st_nxt.window_stage = 1'b0;
      end else begin
        if (st_r.window_stage && wd == ctl_pkg::UNLOCK_SECOND) begin
          st_nxt.window_cnt = ctl_pkg::WINDOW_CYCLES; // RQ8 RQ9
        end
        st_nxt.window_stage = (wd == ctl_pkg::UNLOCK_FIRST);
      end
    end
    if (wr && hit_clock_sel && window_open) begin // RQ19 RQ23
      st_nxt.system_clock_select = wd; // RQ18 RQ21
    end

    // Unprotected registers
    if (wr && hit_manage) begin
      st_nxt.divider_ctl_low = wd[ctl_pkg::DIV_LOW_BIT];
      st_nxt.auto_return_bit = wd[ctl_pkg::DIV_AUTO_RET_BIT];
    end
    if (wr && hit_mode) begin
      st_nxt.baud_double_reserved = wd[ctl_pkg::MODE_BAUD_BIT];
    end

    // Power modes; single guard keeps its state in every mode, timed window keeps counting down
    st_nxt.settle_cnt = 9'h000; // RQ12
    case (st_r.pwr)
      ctl_pkg::PWR_RUN: begin
        if (wr && hit_mode) begin
          if (wd[ctl_pkg::MODE_STOP_BIT] && wd[ctl_pkg::MODE_SLEEP_BIT]) begin
            st_nxt.pwr = ctl_pkg::PWR_SLEEP; // RQ15
          end else if (wd[ctl_pkg::MODE_STOP_BIT]) begin
            st_nxt.pwr = ctl_pkg::PWR_STOP; // RQ14
          end else if (wd[ctl_pkg::MODE_IDLE_BIT]) begin
            st_nxt.pwr = ctl_pkg::PWR_IDLE; // RQ13
          end
        end
      end
      ctl_pkg::PWR_IDLE: begin
        if (idle_wake_in || wake) begin
          st_nxt.pwr = ctl_pkg::PWR_RUN; // RQ13
        end
      end
      ctl_pkg::PWR_STOP: begin
        if (wake) begin
          st_nxt.pwr = ctl_pkg::PWR_RUN; // RQ14
        end
      end
      ctl_pkg::PWR_SLEEP: begin
        if (wake) begin
          st_nxt.pwr = ctl_pkg::PWR_SETTLE; // RQ16
        end
      end
      ctl_pkg::PWR_SETTLE: begin
        st_nxt.settle_cnt = st_r.settle_cnt;
        if (slow_tick) begin
          if (st_r.settle_cnt >= settle_limit - 9'h001) begin
            st_nxt.pwr = ctl_pkg::PWR_RUN; // RQ20
          end else begin
            st_nxt.settle_cnt = st_r.settle_cnt + 9'h001;
          end
        end
      end
      default: begin
        st_nxt.pwr = ctl_pkg::PWR_RUN;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r                      <= '0;
      st_r.pwr                  <= ctl_pkg::PWR_SETTLE;
      st_r.baud_double_reserved <= ctl_pkg::RST_POWER_MODE[ctl_pkg::MODE_BAUD_BIT];
      st_r.system_clock_select  <= ctl_pkg::RST_CLOCK_SEL;
      st_r.divider_ctl_low      <= ctl_pkg::RST_MANAGE_DIV[ctl_pkg::DIV_LOW_BIT];
      st_r.auto_return_bit      <= ctl_pkg::RST_MANAGE_DIV[ctl_pkg::DIV_AUTO_RET_BIT];
      st_r.memory_config_reg    <= ctl_pkg::RST_MEM_CFG;
      st_r.address_config_reg   <= ctl_pkg::RST_ADDR_CFG;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata_out           = st_r.rdata;
  assign cpu_clk_stop_out     = (st_r.pwr != ctl_pkg::PWR_RUN);
  assign periph_clk_stop_out  = (st_r.pwr != ctl_pkg::PWR_RUN)
                              && (st_r.pwr != ctl_pkg::PWR_IDLE);
  assign regulator_off_out    = (st_r.pwr == ctl_pkg::PWR_SLEEP);
  assign clock_source_out     = st_r.system_clock_select[1:0];
  assign fast_osc_divisor_out = ctl_pkg::prescale_ratio(st_r.system_clock_select[7:4]);
  assign full_speed_out       = st_r.divider_ctl_low; // RQ17
  assign auto_return_out      = st_r.auto_return_bit;
  assign memory_config_out    = st_r.memory_config_reg;
  assign address_config_out   = st_r.address_config_reg;
  assign watchdog_restart_out = st_r.watchdog_restart;
  assign guard_unlocked_out   = st_r.guard_unlocked_flag;
  assign window_open_out      = window_open;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic guard55_w;
  logic window_arm_w;
  logic window_wr_w;
  assign guard55_w    = wr && hit_guard && wd == ctl_pkg::UNLOCK_SECOND;
  assign window_arm_w = wr && hit_window && st_r.window_stage
                      && wd == ctl_pkg::UNLOCK_SECOND;
  assign window_wr_w  = wr && hit_window;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  guard_arm_a: assert property ($rose(guard_unlocked_out) |-> $past(guard55_w)) // RQ1
    else $error("guard unlocked without 0x55 write");
  guard_consume_a: assert property (prot_wr && guard_unlocked_out |=> !guard_unlocked_out) // RQ2
    else $error("guard not consumed by protected write");
  guard_cancel_a: assert property (acc && hit_guard && guard_unlocked_out
                                   |=> !guard_unlocked_out) // RQ6
    else $error("guard access did not relock");
  window_len_a: assert property ($fell(window_open_out) && !$past(window_wr_w)
                                 |-> $past(window_arm_w, 257)) // RQ8
    else $error("window length wrong");
  window_close_a: assert property (window_wr_w && wd == ctl_pkg::WINDOW_CLOSE
                                   |=> !window_open_out) // RQ10
    else $error("window not closed");
  clock_sel_locked_a: assert property (wr && hit_clock_sel && !window_open_out
                                    |=> $stable(clock_source_out)
                                        && $stable(fast_osc_divisor_out)) // RQ19
    else $error("clock select changed while locked");
  sleep_exit_a: assert property (st_r.pwr == ctl_pkg::PWR_SLEEP && wake
                                 |=> !regulator_off_out && periph_clk_stop_out) // RQ16
    else $error("sleep exit wrong");
  restart_guard_a: assert property (watchdog_restart_out |-> $past(guard_unlocked_out)) // RQ22
    else $error("restart without guard");
  div_high_zero_a: assert property (acc && hit_manage && !req.pwrite
                                    |-> prdata_out[7] == 1'b0) // RQ17
    else $error("upper divider bit not zero");

  guard_use_c: cover property ($rose(guard_unlocked_out) ##[1:20] $fell(guard_unlocked_out));
  window_expire_c: cover property (window_arm_w ##257 !window_open_out);
  sleep_round_c: cover property (regulator_off_out ##[1:50] !periph_clk_stop_out);
  idle_round_c: cover property ($rose(cpu_clk_stop_out) && !periph_clk_stop_out
                                ##[1:20] !cpu_clk_stop_out);

endmodule

`default_nettype wire

/* ctl_pkg.sv */
// Constants and types for the write guard, power and clock control block
`default_nettype none
package ctl_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_POWER_MODE_CONTROL  = 8'h87;
  localparam logic [7:0] IDX_SYSTEM_CLOCK_SELECT = 8'h8f;
  localparam logic [7:0] IDX_POWER_MANAGE_DIV    = 8'hc4;
  localparam logic [7:0] IDX_SINGLE_WRITE_GUARD  = 8'hc7;
  localparam logic [7:0] IDX_TIMED_WINDOW_GUARD  = 8'hc9;
  localparam logic [7:0] IDX_WATCHDOG_CONTROL    = 8'hd8;
  localparam logic [7:0] IDX_MEMORY_CONFIG       = 8'hc6;
  localparam logic [7:0] IDX_ADDRESS_CONFIG      = 8'h9d;

  // ---------------------------------------------------------------
  // Unlock codes
  // ---------------------------------------------------------------
  localparam logic [7:0] UNLOCK_FIRST  = 8'haa;
  localparam logic [7:0] UNLOCK_SECOND = 8'h55;
  localparam logic [7:0] WINDOW_CLOSE  = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MODE_IDLE_BIT    = 0;
  localparam int MODE_STOP_BIT    = 1;
  localparam int MODE_SLEEP_BIT   = 2;
  localparam int MODE_BAUD_BIT    = 7;
  localparam int DIV_LOW_BIT      = 6;
  localparam int DIV_AUTO_RET_BIT = 5;
  localparam int RESTART_BIT      = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_POWER_MODE = 8'h00;
  localparam logic [7:0] RST_CLOCK_SEL  = 8'h0c;
  localparam logic [7:0] RST_MANAGE_DIV = 8'h40;
  localparam logic [7:0] RST_MEM_CFG    = 8'h00;
  localparam logic [7:0] RST_ADDR_CFG   = 8'h00;

  // ---------------------------------------------------------------
  // Cycle counts
  // ---------------------------------------------------------------
  localparam logic [8:0] WINDOW_CYCLES = 9'h100;
  localparam logic [8:0] SETTLE_CODE0  = 9'h008;
  localparam logic [8:0] SETTLE_CODE1  = 9'h010;
  localparam logic [8:0] SETTLE_CODE2  = 9'h040;
  localparam logic [8:0] SETTLE_CODE3  = 9'h100;

  typedef enum logic [2:0] {
    PWR_RUN    = 3'b000,
    PWR_IDLE   = 3'b001,
    PWR_STOP   = 3'b010,
    PWR_SLEEP  = 3'b011,
    PWR_SETTLE = 3'b100
  } pwr_state_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    pwr_state_type pwr;
    logic [8:0]    settle_cnt;
    logic          guard_stage;
    logic          guard_unlocked_flag;
    logic          window_stage;
    logic [8:0]    window_cnt;
    logic          baud_double_reserved;
    logic [7:0]    system_clock_select;
    logic          divider_ctl_low;
    logic          auto_return_bit;
    logic [7:0]    memory_config_reg;
    logic [7:0]    address_config_reg;
    logic          watchdog_restart;
    logic [31:0]   rdata;
    logic [1:0]    wake_sync;
    logic [2:0]    low_speed_sync;
  } ctl_state_type;

  // Divide ratio of the fast oscillator prescaler
  function automatic logic [8:0] prescale_ratio(input logic [3:0] code);
    case (code)
      4'h0:    prescale_ratio = 9'h001;
      4'h9:    prescale_ratio = 9'h020;
      4'ha:    prescale_ratio = 9'h040;
      4'hb:    prescale_ratio = 9'h080;
      4'hc, 4'hd, 4'he, 4'hf: prescale_ratio = 9'h100;
      default: prescale_ratio = {4'h0, code, 1'b0};
    endcase
  endfunction

endpackage

`default_nettype wire

/* write_guard_power_clock_ctl_test.sv */
// Self-checking bench for the write guard, power and clock control block
`timescale 1ns/1ps
`default_nettype none
module write_guard_power_clock_ctl_test;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [9:0]  paddr_in = 10'h000;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic        wake_in = 1'b0;
  logic        idle_wake_in = 1'b0;
  logic        low_speed_clk_in = 1'b0;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, cpu_clk_stop_out, periph_clk_stop_out;
  logic        regulator_off_out, full_speed_out, auto_return_out;
  logic        watchdog_restart_out, guard_unlocked_out, window_open_out;
  logic [1:0]  clock_source_out;
  logic [8:0]  fast_osc_divisor_out;
  logic [7:0]  memory_config_out, address_config_out;
  wire  [2:0]  stops = {cpu_clk_stop_out, periph_clk_stop_out, regulator_off_out};
  logic [31:0] rd;
  logic        err;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          restarts = 0;
  int          slow_cnt = 0;
  int          ls_div = 0;
  int          settle_n[4] = '{8, 16, 64, 256};

  write_guard_power_clock_ctl dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .wake_in(wake_in), .idle_wake_in(idle_wake_in), .low_speed_clk_in(low_speed_clk_in),
    .cpu_clk_stop_out(cpu_clk_stop_out), .periph_clk_stop_out(periph_clk_stop_out),
    .regulator_off_out(regulator_off_out), .clock_source_out(clock_source_out),
    .fast_osc_divisor_out(fast_osc_divisor_out), .full_speed_out(full_speed_out),
    .auto_return_out(auto_return_out), .memory_config_out(memory_config_out),
    .address_config_out(address_config_out), .watchdog_restart_out(watchdog_restart_out),
    .guard_unlocked_out(guard_unlocked_out), .window_open_out(window_open_out)
  );

  always #5 clk_in = ~clk_in;

  // ------------------------------------------------------------
  // Slow oscillator, restart pulse count, timeout
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    ls_div <= ls_div + 1;
    if (ls_div[0]) begin
      low_speed_clk_in <= ~low_speed_clk_in;
      if (low_speed_clk_in == 1'b0) begin
        slow_cnt <= slow_cnt + 1;
      end
    end
    if (watchdog_restart_out === 1'b1) begin
      restarts <= restarts + 1;
    end
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tk();
    @(posedge clk_in);
  endtask

  task automatic apb(input logic wr_en, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr_en;
    paddr_in <= {idx, 2'b00};
    pwdata_in <= {24'h000000, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, {24'h000000, exp}, "register read");
  endtask

  task automatic unlock();
    wr(ctl_pkg::IDX_SINGLE_WRITE_GUARD, 8'haa);
    wr(ctl_pkg::IDX_SINGLE_WRITE_GUARD, 8'h55);
  endtask

  task automatic open_win();
    wr(ctl_pkg::IDX_TIMED_WINDOW_GUARD, 8'haa);
    wr(ctl_pkg::IDX_TIMED_WINDOW_GUARD, 8'h55);
  endtask

  task automatic win_len(output int n);
    n = 0;
    forever begin
      @(posedge clk_in);
      if (window_open_out !== 1'b1) break;
      n++;
    end
  endtask

  function automatic logic [8:0] ratio(input int c);
    if (c == 0) return 9'h001;
    if (c <= 8) return 9'(2 * c);
    if (c <= 11) return 9'h020 << (c - 9);
    return 9'h100;
  endfunction

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_single();
    int r0;
    wr(ctl_pkg::IDX_MEMORY_CONFIG, 8'h11);
    rc(ctl_pkg::IDX_MEMORY_CONFIG, 8'h00);
    wr(ctl_pkg::IDX_SINGLE_WRITE_GUARD, 8'h55);
    tk();
    check(guard_unlocked_out, 1'b0, "lone second code");
    unlock();
    tk();
    check(guard_unlocked_out, 1'b1, "armed");
    repeat (300) tk();
    check(guard_unlocked_out, 1'b1, "armed after wait");
    rc(ctl_pkg::IDX_SINGLE_WRITE_GUARD, 8'h01);
    tk();
    check(guard_unlocked_out, 1'b0, "relock on access");
    unlock();
    wr(ctl_pkg::IDX_MEMORY_CONFIG, 8'h5a);
    wr(ctl_pkg::IDX_MEMORY_CONFIG, 8'h33);
    rc(ctl_pkg::IDX_MEMORY_CONFIG, 8'h5a);
    check(memory_config_out, 8'h5a, "memory config");
    unlock();
    rc(ctl_pkg::IDX_MEMORY_CONFIG, 8'h5a);
    wr(ctl_pkg::IDX_ADDRESS_CONFIG, 8'hc3);
    rc(ctl_pkg::IDX_ADDRESS_CONFIG, 8'hc3);
    check(address_config_out, 8'hc3, "address config");
    r0 = restarts;
    wr(ctl_pkg::IDX_WATCHDOG_CONTROL, 8'h01);
    unlock();
    wr(ctl_pkg::IDX_WATCHDOG_CONTROL, 8'h01);
    repeat (3) tk();
    check(restarts - r0, 1, "restart pulses");
  endtask

  task automatic t_window();
    int n;
    wr(ctl_pkg::IDX_SYSTEM_CLOCK_SELECT, 8'h91);
    rc(ctl_pkg::IDX_SYSTEM_CLOCK_SELECT, 8'h00);
    open_win();
    win_len(n);
    check(n, 256, "window length");
    open_win();
    repeat (100) tk();
    open_win();
    win_len(n);
    check(n, 256, "restarted window");
    open_win();
    for (int c = 0; c < 16; c++) begin
      wr(ctl_pkg::IDX_SYSTEM_CLOCK_SELECT, {c[3:0], 2'b00, c[1:0]});
      tk();
      check({clock_source_out, fast_osc_divisor_out}, {c[1:0], ratio(c)}, "clock");
    end
    rc(ctl_pkg::IDX_TIMED_WINDOW_GUARD, 8'h01);
    wr(ctl_pkg::IDX_TIMED_WINDOW_GUARD, 8'h00);
    tk();
    check(window_open_out, 1'b0, "closed");
    wr(ctl_pkg::IDX_SYSTEM_CLOCK_SELECT, 8'h00);
    rc(ctl_pkg::IDX_SYSTEM_CLOCK_SELECT, 8'hf3);
  endtask

  task automatic t_power();
    int s;
    wr(ctl_pkg::IDX_POWER_MANAGE_DIV, 8'hc0);
    rc(ctl_pkg::IDX_POWER_MANAGE_DIV, 8'h40);
    wr(ctl_pkg::IDX_POWER_MANAGE_DIV, 8'h20);
    rc(ctl_pkg::IDX_POWER_MANAGE_DIV, 8'h20);
    check({full_speed_out, auto_return_out}, 2'b01, "divider bits");
    wr(ctl_pkg::IDX_POWER_MODE_CONTROL, 8'h80);
    rc(ctl_pkg::IDX_POWER_MODE_CONTROL, 8'h80);
    wr(ctl_pkg::IDX_POWER_MODE_CONTROL, 8'h01);
    tk();
    check(stops, 3'b100, "idle");
    idle_wake_in <= 1'b1;
    tk();
    idle_wake_in <= 1'b0;
    repeat (2) tk();
    check(stops, 3'b000, "idle exit");
    unlock();
    wr(ctl_pkg::IDX_POWER_MODE_CONTROL, 8'h02);
    repeat (20) tk();
    check(stops, 3'b110, "stop");
    wake_in <= 1'b1;
    repeat (6) tk();
    wake_in <= 1'b0;
    check(stops, 3'b000, "stop exit");
    rc(ctl_pkg::IDX_SINGLE_WRITE_GUARD, 8'h01);
    for (int c = 0; c < 4; c++) begin
      open_win();
      wr(ctl_pkg::IDX_SYSTEM_CLOCK_SELECT, {4'h0, c[1:0], 2'b00});
      wr(ctl_pkg::IDX_TIMED_WINDOW_GUARD, 8'h00);
      wr(ctl_pkg::IDX_POWER_MODE_CONTROL, 8'h06);
      repeat (3) tk();
      check(stops, 3'b111, "sleep");
      wake_in <= 1'b1;
      while (regulator_off_out !== 1'b0) tk();
      s = slow_cnt;
      wake_in <= 1'b0;
      while (cpu_clk_stop_out !== 1'b0) tk();
      s = slow_cnt - s;
      check(s >= settle_n[c] - 1 && s <= settle_n[c] + 2, 1, "settle length");
      repeat (10) tk();
      check(stops, 3'b000, "run after sleep");
    end
  endtask

  initial begin
    int s;
    repeat (20) @(posedge clk_in);
    check(cpu_clk_stop_out, 1'b1, "settle in reset");
    check({clock_source_out, fast_osc_divisor_out}, 11'h001, "reset clock");
    rst_n_in <= 1'b1;
    s = slow_cnt;
    while (cpu_clk_stop_out !== 1'b0) @(posedge clk_in);
    s = slow_cnt - s;
    check(s >= 255 && s <= 258, 1, "reset settle");
    rc(ctl_pkg::IDX_POWER_MODE_CONTROL, 8'h00);
    rc(ctl_pkg::IDX_SYSTEM_CLOCK_SELECT, 8'h00);
    rc(ctl_pkg::IDX_POWER_MANAGE_DIV, 8'h40);
    rc(ctl_pkg::IDX_SINGLE_WRITE_GUARD, 8'h00);
    rc(ctl_pkg::IDX_TIMED_WINDOW_GUARD, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    check(err, 1'b1, "unmapped error");
    t_single();
    t_window();
    t_power();
    stop_test();
  end
endmodule
`default_nettype wire
